/* File: inc/jtp_consts.svh */
// Constants for the output test pattern generator: offsets, fields, resets
`ifndef JTP_CONSTS_SVH
`define JTP_CONSTS_SVH
`define JTP_OFS_TRANSPORT_CTRL 8'h01
`define JTP_OFS_LINK_CTRL 8'h03
`define JTP_OFS_PAT_SEL_A 8'h37
`define JTP_OFS_PAT_SEL_B 8'h38
`define JTP_OFS_CUST1_HI 8'h75
`define JTP_OFS_CUST1_LO 8'h76
`define JTP_OFS_CUST2_HI 8'h77
`define JTP_OFS_CUST2_LO 8'h78
`define JTP_OFS_CTRL 8'h79
`define JTP_OFS_STATUS 8'h7A
`define JTP_LTT_BIT 4
`define JTP_LINK_SEL_HI 7
`define JTP_LINK_SEL_LO 5
`define JTP_CTRL_SCR_BIT 0
`define JTP_CTRL_SYSREF_BIT 1
`define JTP_CTRL_ILA_RESTART_BIT 2
`define JTP_RST_BYTE 8'h00
`define JTP_RST_WORD 16'h0000
`define JTP_TOGGLE_WORD 16'hAAAA
`define JTP_DESKEW_WORD 16'h0FFF
`define JTP_K28_5 8'hBC
`define JTP_D21_5 8'hB5
`define JTP_K28_0 8'h1C
`define JTP_K28_3 8'h7C
`define JTP_ILA_MULTIFRAMES 4
`define JTP_RPAT_LEN 12
`endif

/* File: inc/jtp_pkg.sv */
// Types shared by the output test pattern generator modules
package jtp_pkg;
    typedef enum logic [3:0] {
        PAT_NORMAL = 4'h0, PAT_ZEROS = 4'h1, PAT_ONES = 4'h2,
        PAT_TOGGLE = 4'h3, PAT_RAMP = 4'h4, PAT_CUSTOM1 = 4'h6,
        PAT_CUSTOM12 = 4'h7, PAT_DESKEW = 4'h8
    } jtp_pat_type;
    typedef enum logic [2:0] {
        LNK_NORMAL = 3'h0, LNK_D215 = 3'h1, LNK_K285 = 3'h2,
        LNK_ILA_RPT = 3'h3, LNK_RPAT = 3'h4
    } jtp_link_type;
    typedef enum {ST_CGS, ST_ILA, ST_DATA} jtp_link_state_type;
endpackage

/* File: inc/jtp_fifo_if.sv */
// Valid/ready word carrier between the generator and its FIFO
`timescale 1ns/100ps
interface jtp_fifo_if #(parameter int WIDTH = 16);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface

/* File: design/jtp_fifo.sv */
// Word FIFO with valid/ready on both sides
`timescale 1ns/100ps
module jtp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Fill side
    jtp_fifo_if.sink wr,
    // Drain side
    output logic rd_valid,
    output logic [WIDTH-1:0] rd_data,
    input wire logic rd_ready
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic [WIDTH-1:0] dout;
        logic dvalid;
    } jtp_fifo_state_type;
    jtp_fifo_state_type s_reg, s_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;

    // Handshakes: full stalls the filler, read register refills on pop
    assign wr.ready = (s_reg.cnt != (AW+1)'(DEPTH));
    assign push = wr.valid && wr.ready;
    assign pop = (s_reg.cnt != '0) && (!s_reg.dvalid || rd_ready);
    assign rd_valid = s_reg.dvalid;
    assign rd_data = s_reg.dout;

    // Next state
    always_comb
    begin
        s_next = s_reg;
        if (rd_ready)
            s_next.dvalid = 1'b0;
        if (push)
            s_next.wp = (s_reg.wp == AW'(DEPTH-1)) ? '0 : s_reg.wp + 1'b1;
        if (pop)
        begin
            s_next.rp = (s_reg.rp == AW'(DEPTH-1)) ? '0 : s_reg.rp + 1'b1;
            s_next.dout = mem[s_reg.rp];
            s_next.dvalid = 1'b1;
        end
        s_next.cnt = s_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Storage has no reset; pointers, count and read register need a known value
    always_ff @(posedge clk)
    begin
        if (push)
            mem[s_reg.wp] <= wr.data;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end
endmodule // jtp_fifo

/* File: design/jtp_gen.sv */
// Output test pattern generator: sample, transport and link layer patterns
`timescale 1ns/100ps
`include "jtp_consts.svh"
// Behaviour
// - Selected pattern replaces samples independently for each of the two channels' streams.
// - Sample pattern selector active only with down-converter on; held at 37h for channel A, 38h for channel B.
// - Codes 0000 normal, 0001 all zeros, 0010 all ones.
// - Code 0011 alternates 1010 word and its complement per clock.
// - Code 0100 ramps up one LSB per clock, 0 to 65535, wraps.
// - Code 0110 outputs custom pattern one from 75h and 76h.
// - Code 0111 alternates custom pattern one and two per clock.
// - Code 1000 outputs deskew word FFFh.
// - Complex or dual-band mode adds two streams per channel, same pattern.
// - SYSREF can restart both channels' pattern sequences together.
// - A 16-bit wide pattern is available in place of samples.
// - Transport packs samples into octets per frame, pads with zeros.
// - Bit 4 of 01h sends long transport test pattern; resets 0.
// - Link layer scrambles transport octets, then encodes them.
// - Link layer sends lane alignment and software can restart it.
// - Link test patterns inserted after encoder, bypassing it; code 011 lane alignment still goes through it.
// - Bits 7-5 of 03h: 000 normal, 001 D21.5, 010 K28.5.
// - Code 011 repeats lane alignment; code 100 sends 12-octet RPAT.
// - Custom AAAAh with scrambling on yields PRBS through the encoder.
// - While sync request low, send K28.5 continuously; link codes 001, 010 and 100 send their pattern instead.
// - After release, start alignment at multiframe boundary, four multiframes.
module jtp_gen #(
    parameter int STREAMS = 8,
    parameter int FRAME_OCTETS = 2,
    parameter int MF_FRAMES = 4,
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_B,
    // Register port
    input wire logic REG_WR,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    // Converter samples, one 16-bit word per stream
    input wire logic [STREAMS*16-1:0] SAMPLE_IN,
    input wire logic DDC_ENABLE,
    input wire logic COMPLEX_MODE,
    // Link timing
    input wire logic SYSREF,
    input wire logic SYNC_REQ_B,
    // Lane output: octet and control flag
    output logic LANE_VALID,
    output logic [7:0] LANE_OCTET,
    output logic LANE_IS_K,
    output logic LANE_ENCODE,
    input wire logic LANE_READY
);
    localparam int FW = $clog2(FRAME_OCTETS*MF_FRAMES+1);
    localparam int ACT = STREAMS / 2;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] tctl;
        logic [7:0] lctl;
        logic [7:0] sel_a;
        logic [7:0] sel_b;
        logic [15:0] cust1;
        logic [15:0] cust2;
        logic [7:0] ctl;
        logic [3:0] pat_act;
        logic [2:0] lnk_act;
        logic ltt_act;
        logic [15:0] ramp;
        logic phase;
        logic [15:0] lfsr;
        logic [FW-1:0] oct;
        logic [2:0] mf;
        logic [3:0] rpat;
        jtp_pkg::jtp_link_state_type st;
        logic [STREAMS*16-1:0] words;
        logic sysref_d;
    } jtp_state_type;
    jtp_state_type s_reg, s_next;

    jtp_fifo_if #(.WIDTH(10)) fif ();
    logic [9:0] fifo_out;
    logic fifo_rd_valid;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Unlisted codes fall back to normal data
    function automatic logic [3:0] pat_legal(input logic [3:0] c);
        unique case (c)
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8: return c;
            default: return 4'h0;
        endcase
    endfunction

    function automatic logic [2:0] lnk_legal(input logic [2:0] c);
        return (c > 3'h4) ? 3'h0 : c;
    endfunction

    // Register reads decoded once, used by read mux
    function automatic logic [7:0] reg_read(input jtp_state_type s,
                                            input logic [7:0] a);
        unique case (a)
            `JTP_OFS_TRANSPORT_CTRL: return s.tctl;
            `JTP_OFS_LINK_CTRL: return s.lctl;
            `JTP_OFS_PAT_SEL_A: return s.sel_a;
            `JTP_OFS_PAT_SEL_B: return s.sel_b;
            `JTP_OFS_CUST1_HI: return s.cust1[15:8];
            `JTP_OFS_CUST1_LO: return s.cust1[7:0];
            `JTP_OFS_CUST2_HI: return s.cust2[15:8];
            `JTP_OFS_CUST2_LO: return s.cust2[7:0];
            `JTP_OFS_CTRL: return s.ctl;
            `JTP_OFS_STATUS: return {3'h0, s.st == jtp_pkg::ST_DATA,
                                     s.pat_act};
            default: return 8'h00;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Per-stream pattern mux
    // ------------------------------------------------------------
    logic [STREAMS*16-1:0] pat_words;
    logic [3:0] code_a, code_b;
    assign code_a = DDC_ENABLE ? s_reg.pat_act : 4'h0;
    assign code_b = DDC_ENABLE ? pat_legal(s_reg.sel_b[3:0]) : 4'h0;

    genvar g;
    generate
        for (g = 0; g < STREAMS; g++)
        begin : g_stream
            logic [3:0] code;
            logic [15:0] w;
            logic used;
            // Half the streams serve channel A; extra I/Q pair gated
            assign code = (g < ACT) ? code_a : code_b;
            assign used = COMPLEX_MODE || ((g % ACT) < (ACT / 2));
            always_comb
            begin
                unique case (code)
                    4'h1: w = `JTP_RST_WORD;
                    4'h2: w = 16'hFFFF;
                    4'h3: w = s_reg.phase ? ~`JTP_TOGGLE_WORD
                                          : `JTP_TOGGLE_WORD;
                    4'h4: w = s_reg.ramp;
                    4'h6: w = s_reg.cust1;
                    4'h7: w = s_reg.phase ? s_reg.cust2 : s_reg.cust1;
                    4'h8: w = `JTP_DESKEW_WORD;
                    default: w = SAMPLE_IN[g*16 +: 16];
                endcase
            end
            assign pat_words[g*16 +: 16] = used ? w : 16'h0000;
        end
    endgenerate

    // ------------------------------------------------------------
    // Transport octet and link framing
    // ------------------------------------------------------------
    logic [7:0] tr_octet, scr_octet, out_octet;
    logic [15:0] lfsr_adv;
    logic out_k, out_enc, frame_end, mf_end, frame_start, do_step;
    logic [FW-1:0] oct_in_frame;
    logic [STREAMS*16-1:0] sh;

    assign oct_in_frame = FW'(s_reg.oct % FW'(FRAME_OCTETS));
    assign frame_start = (oct_in_frame == '0);
    assign frame_end = (oct_in_frame == FW'(FRAME_OCTETS-1));
    assign mf_end = (s_reg.oct == FW'(FRAME_OCTETS*MF_FRAMES-1));
    assign do_step = fif.ready;
    assign sh = s_reg.words >> (16 * (32'(oct_in_frame) >> 1));

    // Octet from current frame's held words, high byte first
    always_comb
    begin
        tr_octet = oct_in_frame[0] ? sh[7:0] : sh[15:8];
        if (s_reg.ltt_act)
            tr_octet = {4'(oct_in_frame), 4'(s_reg.oct / FW'(FRAME_OCTETS))};
    end

    // Self-synchronous scrambler 1 + x^14 + x^15, msb first
    always_comb
    begin
        lfsr_adv = s_reg.lfsr;
        scr_octet = tr_octet;
        for (int i = 7; i >= 0; i--)
        begin
            scr_octet[i] = tr_octet[i] ^ lfsr_adv[14] ^ lfsr_adv[13];
            lfsr_adv = {lfsr_adv[14:0], scr_octet[i]};
        end
    end

    // Link output select; D21.5, K28.5 and RPAT patterns skip the encoder
    always_comb
    begin
        out_octet = s_reg.ctl[`JTP_CTRL_SCR_BIT] ? scr_octet : tr_octet;
        out_k = 1'b0;
        out_enc = 1'b1;
        unique case (s_reg.st)
            jtp_pkg::ST_CGS:
            begin
                out_octet = `JTP_K28_5;
                out_k = 1'b1;
            end
            jtp_pkg::ST_ILA:
            begin
                out_k = frame_start || frame_end;
                out_octet = frame_end ? `JTP_K28_3
                          : (frame_start ? `JTP_K28_0 : tr_octet);
            end
            jtp_pkg::ST_DATA: ;
        endcase
        unique case (s_reg.lnk_act)
            jtp_pkg::LNK_D215:
            begin
                out_octet = `JTP_D21_5;
                out_k = 1'b0;
                out_enc = 1'b0;
            end
            jtp_pkg::LNK_K285:
            begin
                out_octet = `JTP_K28_5;
                out_k = 1'b1;
                out_enc = 1'b0;
            end
            jtp_pkg::LNK_RPAT:
            begin
                out_octet = 8'(8'hBE + 8'(s_reg.rpat) * 8'h1D);
                out_k = 1'b0;
                out_enc = 1'b0;
            end
            default: ;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        s_next = s_reg;
        s_next.sysref_d = SYSREF;
        if (REG_WR)
        begin
            unique case (REG_ADDR)
                `JTP_OFS_TRANSPORT_CTRL: s_next.tctl = REG_WDATA;
                `JTP_OFS_LINK_CTRL: s_next.lctl = REG_WDATA;
                `JTP_OFS_PAT_SEL_A: s_next.sel_a = REG_WDATA;
                `JTP_OFS_PAT_SEL_B: s_next.sel_b = REG_WDATA;
                `JTP_OFS_CUST1_HI: s_next.cust1[15:8] = REG_WDATA;
                `JTP_OFS_CUST1_LO: s_next.cust1[7:0] = REG_WDATA;
                `JTP_OFS_CUST2_HI: s_next.cust2[15:8] = REG_WDATA;
                `JTP_OFS_CUST2_LO: s_next.cust2[7:0] = REG_WDATA;
                `JTP_OFS_CTRL: s_next.ctl = REG_WDATA;
                default: ;
            endcase
        end
        // Pattern counters advance every clock
        s_next.ramp = s_reg.ramp + 16'h0001;
        s_next.phase = ~s_reg.phase;
        if (SYSREF && !s_reg.sysref_d && s_reg.ctl[`JTP_CTRL_SYSREF_BIT])
        begin
            s_next.ramp = `JTP_RST_WORD;
            s_next.phase = 1'b0;
        end
        if (do_step)
        begin
            s_next.lfsr = s_reg.ctl[`JTP_CTRL_SCR_BIT] ? lfsr_adv
                                                      : s_reg.lfsr;
            s_next.oct = mf_end ? '0 : s_reg.oct + 1'b1;
            s_next.rpat = (s_reg.rpat == 4'(`JTP_RPAT_LEN-1))
                        ? 4'h0 : s_reg.rpat + 4'h1;
            if (frame_end)
            begin
                // Selectors and samples latched only between frames
                s_next.words = pat_words;
                s_next.pat_act = pat_legal(s_reg.sel_a[3:0]);
                s_next.lnk_act = lnk_legal(
                    s_reg.lctl[`JTP_LINK_SEL_HI:`JTP_LINK_SEL_LO]);
                s_next.ltt_act = s_reg.tctl[`JTP_LTT_BIT];
            end
            if (mf_end && s_reg.st == jtp_pkg::ST_CGS && SYNC_REQ_B)
            begin
                s_next.st = jtp_pkg::ST_ILA;
                s_next.mf = 3'h0;
            end
            else if (mf_end && s_reg.st == jtp_pkg::ST_ILA)
            begin
                s_next.mf = s_reg.mf + 3'h1;
                if (s_reg.mf == 3'(`JTP_ILA_MULTIFRAMES-1)
                    && s_reg.lnk_act != jtp_pkg::LNK_ILA_RPT)
                    s_next.st = jtp_pkg::ST_DATA;
                else if (s_reg.mf == 3'(`JTP_ILA_MULTIFRAMES-1))
                    s_next.mf = 3'h0;
            end
            // Repeat mode also pulls a running link back to commas
            else if (mf_end && s_reg.lnk_act == jtp_pkg::LNK_ILA_RPT)
                s_next.st = jtp_pkg::ST_CGS;
        end
        // Self-clearing restart bit; a fresh write of it wins
        if (s_reg.ctl[`JTP_CTRL_ILA_RESTART_BIT])
        begin
            if (!REG_WR || REG_ADDR != `JTP_OFS_CTRL)
                s_next.ctl[`JTP_CTRL_ILA_RESTART_BIT] = 1'b0;
            s_next.st = jtp_pkg::ST_CGS;
        end
        if (!SYNC_REQ_B)
            s_next.st = jtp_pkg::ST_CGS;
    end

    // Register all state; everything resets to zero
    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            s_reg <= '0;
            s_reg.st <= jtp_pkg::ST_CGS;
        end
        else
            s_reg <= s_next;
    end

    // ------------------------------------------------------------
    // Output FIFO; a stalled lane holds the framer
    // ------------------------------------------------------------
    assign fif.valid = 1'b1;
    assign fif.data = {out_enc, out_k, out_octet};

    jtp_fifo #(.WIDTH(10), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(SYS_CLK),
        .rst_b(RST_B),
        .wr(fif.sink),
        .rd_valid(fifo_rd_valid),
        .rd_data(fifo_out),
        .rd_ready(LANE_READY)
    );

    assign LANE_VALID = fifo_rd_valid;
    assign LANE_OCTET = fifo_out[7:0];
    assign LANE_IS_K = fifo_out[8];
    assign LANE_ENCODE = fifo_out[9];
    assign REG_RDATA = reg_read(s_reg, REG_ADDR);
endmodule // jtp_gen

/* File: verification/jtp_gen_sva.sv */
// Port assertions for the output test pattern generator
`timescale 1ns/100ps
module jtp_gen_sva (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_B,
    // Register port
    input wire logic REG_WR,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    // Sync and lane
    input wire logic SYNC_REQ_B,
    input wire logic LANE_VALID,
    input wire logic [7:0] LANE_OCTET,
    input wire logic LANE_IS_K,
    input wire logic LANE_ENCODE,
    input wire logic LANE_READY
);
    // --------
    // Helpers
    // --------
    logic [2:0] code_reg;
    logic [5:0] quiet_reg;
    // Octets taken since the last write or sync edge; FIFO leftovers age out
    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            code_reg <= 3'h0;
            quiet_reg <= 6'h00;
        end
        else
        begin
            if (REG_WR && REG_ADDR == 8'h03)
                code_reg <= REG_WDATA[7:5];
            if (REG_WR || $changed(SYNC_REQ_B))
                quiet_reg <= 6'h00;
            else if (LANE_VALID && LANE_READY && quiet_reg != 6'h3F)
                quiet_reg <= quiet_reg + 6'h01;
        end
    end
    // --------
    // Properties
    // --------
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_B);
    sequence s_wr(a);
        REG_WR && REG_ADDR == a ##1 REG_ADDR == a;
    endsequence
    a_sel_readback: assert property (s_wr(8'h37)
        |-> REG_RDATA == $past(REG_WDATA))
        else $error("Selector readback wrong");
    a_link_readback: assert property (s_wr(8'h03)
        |-> ((REG_RDATA ^ $past(REG_WDATA)) & 8'hE0) == 8'h00)
        else $error("Link selector readback wrong");
    a_ltt_readback: assert property (s_wr(8'h01)
        |-> ((REG_RDATA ^ $past(REG_WDATA)) & 8'h10) == 8'h00)
        else $error("Transport test bit readback wrong");
    a_restart_clears: assert property (s_wr(8'h79)
        ##1 REG_ADDR == 8'h79 |-> !REG_RDATA[2])
        else $error("Alignment restart bit stuck");
    a_unmapped_zero: assert property (REG_ADDR == 8'h50
        |-> REG_RDATA == 8'h00)
        else $error("Unmapped read not zero");
    a_lane_hold: assert property (LANE_VALID && !LANE_READY
        |=> LANE_VALID && $stable(LANE_OCTET) && $stable(LANE_IS_K))
        else $error("Lane octet changed before taken");
    a_cgs_comma: assert property (!SYNC_REQ_B && LANE_VALID
        && code_reg == 3'h0 && quiet_reg > 6'h0B
        |-> LANE_IS_K && LANE_OCTET == 8'hBC)
        else $error("No comma during sync request");
    a_link_pattern: assert property (SYNC_REQ_B && LANE_VALID
        && (code_reg == 3'h1 || code_reg == 3'h2) && quiet_reg > 6'h0F
        |-> !LANE_ENCODE && LANE_IS_K == (code_reg == 3'h2)
        && LANE_OCTET == (code_reg == 3'h1 ? 8'hB5 : 8'hBC))
        else $error("Link test pattern octet wrong");
    a_normal_data: assert property (SYNC_REQ_B && LANE_VALID
        && (code_reg == 3'h0 || code_reg > 3'h4) && quiet_reg == 6'h3F
        |-> LANE_ENCODE && !LANE_IS_K)
        else $error("Normal data not encoded");
    a_k_chars: assert property (LANE_VALID && LANE_IS_K
        |-> LANE_OCTET inside {8'hBC, 8'h1C, 8'h7C, 8'h9C})
        else $error("Unexpected control character");
endmodule // jtp_gen_sva
bind jtp_gen jtp_gen_sva u_sva (.SYS_CLK, .RST_B, .REG_WR, .REG_ADDR,
    .REG_WDATA, .REG_RDATA, .SYNC_REQ_B, .LANE_VALID, .LANE_OCTET,
    .LANE_IS_K, .LANE_ENCODE, .LANE_READY);

/* File: verification/jtp_rx_model.sv */
// Receiver model: sync requests and a consumer that may stall
`timescale 1ns/100ps
module jtp_rx_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Bench controls
    input wire logic want_sync,
    input wire logic slow,
    // Lane
    input wire logic lane_valid,
    input wire logic [7:0] lane_octet,
    input wire logic lane_is_k,
    output logic sync_req_b,
    output logic lane_ready
);
    logic [2:0] commas_reg;
    // Release sync only after four commas taken since want_sync last dropped, not necessarily in a row
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sync_req_b <= 1'b0;
            commas_reg <= 3'h0;
            lane_ready <= 1'b0;
        end
        else
        begin
            lane_ready <= !slow || $urandom_range(3) != 0;
            if (want_sync)
                commas_reg <= 3'h0;
            else if (lane_valid && lane_ready && lane_is_k
                && lane_octet == 8'hBC && commas_reg != 3'h4)
                commas_reg <= commas_reg + 3'h1;
            sync_req_b <= !want_sync && commas_reg == 3'h4;
        end
    end
endmodule // jtp_rx_model

/* File: verification/jtp_gen_bench.sv */
// Self-checking bench for the output test pattern generator
`timescale 1ns/100ps
module jtp_gen_bench;
    // --------
    // Signals and instances
    // --------
    logic clk, rst_b, reg_wr, ddc_en, sysref, want_sync, slow;
    logic sync_b, lane_valid, is_k, enc, ready;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, octet, hi;
    logic [127:0] sample_in;
    logic [15:0] word, w, s, c1, c2;
    logic [9:0] raw;
    logic [3:0] codes [7];
    int n_errors, n_tests, n_words, n_raw, dcnt, cyc, cnt;
    jtp_gen uut (.SYS_CLK(clk), .RST_B(rst_b), .REG_WR(reg_wr),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
        .SAMPLE_IN(sample_in), .DDC_ENABLE(ddc_en), .COMPLEX_MODE(1'b1),
        .SYSREF(sysref), .SYNC_REQ_B(sync_b), .LANE_VALID(lane_valid),
        .LANE_OCTET(octet), .LANE_IS_K(is_k), .LANE_ENCODE(enc),
        .LANE_READY(ready));
    jtp_rx_model rx (.clk(clk), .rst_b(rst_b), .want_sync(want_sync),
        .slow(slow), .lane_valid(lane_valid), .lane_octet(octet),
        .lane_is_k(is_k), .sync_req_b(sync_b), .lane_ready(ready));
    // Clock, 25 ns period
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Words rebuilt from data octets; a K restarts frame alignment
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (lane_valid && ready)
        begin
            raw <= {is_k, enc, octet};
            n_raw <= n_raw + 1;
            dcnt <= (is_k || !enc) ? 0 : dcnt + 1;
            if (enc && !is_k && !dcnt[0])
                hi <= octet;
            if (enc && !is_k && dcnt[0])
                word <= {hi, octet};
            if (enc && !is_k && dcnt[0])
                n_words <= n_words + 1;
        end
        if (cyc == 40000)
        begin
            n_errors++;
            final_report();
        end
    end
    // --------
    // Tasks
    // --------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] dat);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= dat;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        @(posedge clk);
        #1 chk({8'h00, reg_rdata}, {8'h00, exp});
    endtask
    // Bounded wait for k more words or octets
    task automatic skip(input int k, input bit by_word);
        repeat (k)
        begin
            cnt = by_word ? n_words : n_raw;
            for (int i = 0; i < 400 && cnt == (by_word ? n_words : n_raw); i++)
                @(posedge clk);
        end
        w = word;
    endtask
    function automatic logic [15:0] ko();
        return {7'h00, raw[9], raw[7:0]};
    endfunction
    function automatic logic [15:0] exp_word(input logic [3:0] code);
        case (code)
            4'h1: return 16'h0000;
            4'h2: return 16'hFFFF;
            4'h6: return c1;
            4'h8: return 16'h0FFF;
            default: return s;
        endcase
    endfunction
    task automatic final_report();
        $display("tests=%0d errors=%0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // --------
    // Main sequence
    // --------
    initial
    begin
        rst_b = 1'b0;
        reg_wr = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        ddc_en = 1'b1;
        sysref = 1'b0;
        want_sync = 1'b1;
        slow = 1'b0;
        void'($urandom(88314));
        c1 = 16'($urandom);
        c2 = 16'($urandom);
        sample_in = 128'h0;
        codes = '{4'h0, 4'h1, 4'h2, 4'h6, 4'h8, 4'h5, 4'hF};
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rchk(8'h01, 8'h00);
        rchk(8'h03, 8'h00);
        rchk(8'h37, 8'h00);
        wr(8'h50, 8'h5A);
        rchk(8'h50, 8'h00);
        $display("test reset_regs done");
        skip(12, 1'b0);
        chk(ko(), 16'h01BC);
        want_sync <= 1'b0;
        for (int j = 0; j < 200 && raw[7:0] == 8'hBC; j++)
            skip(1, 1'b0);
        chk(ko(), 16'h011C);
        $display("test sync done");
        wr(8'h75, c1[15:8]);
        wr(8'h76, c1[7:0]);
        wr(8'h77, c2[15:8]);
        wr(8'h78, c2[7:0]);
        rchk(8'h76, c1[7:0]);
        slow <= 1'b1;
        // Sample codes 0, 1, 2, 6, 8 and unlisted 5, F on both channels, consumer stalling at random
        foreach (codes[i])
        begin
            s = 16'($urandom);
            sample_in <= {8{s}};
            wr(8'h37, {4'h0, codes[i]});
            wr(8'h38, {4'h0, codes[i]});
            skip(12, 1'b1);
            chk(w, exp_word(codes[i]));
        end
        ddc_en <= 1'b0;
        wr(8'h37, 8'h01);
        wr(8'h38, 8'h01);
        skip(12, 1'b1);
        chk(w, s);
        ddc_en <= 1'b1;
        wr(8'h37, 8'h03);
        wr(8'h38, 8'h03);
        skip(12, 1'b1);
        chk({15'h0000, w == 16'hAAAA || w == 16'h5555}, 16'h0001);
        wr(8'h37, 8'h07);
        wr(8'h38, 8'h07);
        skip(12, 1'b1);
        chk({15'h0000, w == c1 || w == c2}, 16'h0001);
        $display("test sample_patterns done");
        wr(8'h37, 8'h02);
        wr(8'h38, 8'h02);
        wr(8'h03, 8'h20);
        skip(24, 1'b0);
        chk({6'h00, raw}, 16'h00B5);
        wr(8'h03, 8'h40);
        skip(24, 1'b0);
        chk({6'h00, raw}, 16'h02BC);
        wr(8'h03, 8'h60);
        for (int j = 0; j < 200 && ko() !== 16'h011C; j++)
            skip(1, 1'b0);
        chk(ko(), 16'h011C);
        wr(8'h03, 8'h80);
        skip(24, 1'b0);
        chk({15'h0000, raw[8]}, 16'h0000);
        wr(8'h03, 8'hC0);
        skip(12, 1'b1);
        chk(w, 16'hFFFF);
        wr(8'h03, 8'h00);
        // Unstalled lane: two-octet frames, ramp two steps per word
        slow <= 1'b0;
        wr(8'h37, 8'h04);
        skip(12, 1'b1);
        s = w;
        skip(1, 1'b1);
        chk(w - s, 16'h0002);
        $display("test link_patterns done");
        wr(8'h01, 8'h10);
        rchk(8'h01, 8'h10);
        wr(8'h01, 8'h00);
        wr(8'h75, 8'hAA);
        wr(8'h76, 8'hAA);
        wr(8'h37, 8'h06);
        wr(8'h79, 8'h01);
        skip(12, 1'b1);
        chk({15'h0000, w != 16'hAAAA}, 16'h0001);
        wr(8'h79, 8'h06);
        rchk(8'h79, 8'h02);
        sysref <= 1'b1;
        for (int j = 0; j < 200 && ko() !== 16'h011C; j++)
            skip(1, 1'b0);
        sysref <= 1'b0;
        chk(ko(), 16'h011C);
        $display("test transport_scramble_restart done");
        final_report();
    end
endmodule // jtp_gen_bench
